// ### verilog/pulse_gear_pkg.sv
// Constants for the command pulse decoder and electronic gear.
// Assumes byte addressing on a 32-bit Avalon-MM register port.
package pulse_gear_pkg;

   // Register byte offsets
   localparam logic [4:0] OFS_CTRL  = 5'h00;
   localparam logic [4:0] OFS_PPR   = 5'h04;
   localparam logic [4:0] OFS_NUM   = 5'h08;
   localparam logic [4:0] OFS_DEN   = 5'h0C;
   localparam logic [4:0] OFS_ENC   = 5'h10;
   localparam logic [4:0] OFS_COUNT = 5'h14;
   localparam logic [4:0] OFS_POS   = 5'h18;
   localparam logic [4:0] OFS_STAT  = 5'h1C;

   // Control field positions
   localparam int CTRL_INV_BIT = 0;
   localparam int CTRL_FMT_LSB = 1;

   // Values after reset
   localparam logic [0:0]  INV_RST = 1'h0;
   localparam logic [1:0]  FMT_RST = 2'h1;
   localparam logic [20:0] PPR_RST = 21'h002710;
   localparam logic [30:0] NUM_RST = 31'h00000000;
   localparam logic [30:0] DEN_RST = 31'h00002710;
   localparam logic [30:0] ENC_RST = 31'h00100000;

   // Input formats
   localparam logic [1:0] FMT_PULSE_PAIR = 2'h1;
   localparam logic [1:0] FMT_PULSE_DIR  = 2'h3;

   // Divider iterations, one per dividend bit
   localparam logic [5:0] DIV_STEPS = 6'h30;

   typedef enum logic [1:0] {
      SC_IDLE = 2'b01,
      SC_WAIT = 2'b10
   } scale_state_e;

endpackage

// ### verilog/gear_divider.sv
// Sequential restoring divider, unsigned 48-bit dividend by 31-bit divisor.
// Assumes start is a one-cycle pulse given only while busy is low.
`timescale 1ns/10ps
`default_nettype none

module gear_divider (
   input  wire  logic        clk,       // System clock
   input  wire  logic        srst,      // Synchronous reset
   input  wire  logic        start,     // Begin a division
   input  wire  logic [47:0] dividend,  // Magnitude to divide
   input  wire  logic [30:0] divisor,   // Nonzero divisor
   output logic              busy,      // Division in progress
   output logic              done,      // Result valid pulse
   output logic [47:0]       quotient,  // Result quotient
   output logic [30:0]       remainder  // Result remainder
);

   logic [5:0]  cnt_r;
   logic [47:0] q_r;
   logic [31:0] r_r;
   logic [30:0] d_r;
   logic [31:0] trial;

   assign trial     = {r_r[30:0], q_r[47]};
   assign quotient  = q_r;
   assign remainder = r_r[30:0];

   // ==========================================================
   // Shift and subtract
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (srst) begin
         busy  <= 1'b0;
         cnt_r <= 6'h00;
         q_r   <= 48'h000000000000;
         r_r   <= 32'h00000000;
         d_r   <= 31'h00000001;
      end else if (start && !busy) begin
         busy  <= 1'b1;
         cnt_r <= pulse_gear_pkg::DIV_STEPS;
         q_r   <= dividend;
         r_r   <= 32'h00000000;
         d_r   <= divisor;
      end else if (busy) begin
         if (trial >= {1'b0, d_r}) begin
            r_r <= trial - {1'b0, d_r};
            q_r <= {q_r[46:0], 1'b1};
         end else begin
            r_r <= trial;
            q_r <= {q_r[46:0], 1'b0};
         end
         cnt_r <= cnt_r - 6'h01;
         if (cnt_r == 6'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ### verilog/command_pulse_decoder_gear.sv
// Command pulse decoder with electronic gear and Avalon-MM settings.
// Assumes pulse inputs are asynchronous pins; one 25 MHz clock.
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module command_pulse_decoder_gear (
   input  wire  logic        clk,              // 25 MHz clock
   input  wire  logic        srst,             // Synchronous reset
   input  wire  logic [4:0]  avs_address,      // Byte address
   input  wire  logic        avs_read,         // Read request
   input  wire  logic        avs_write,        // Write request
   input  wire  logic [31:0] avs_writedata,    // Write data
   input  wire  logic [3:0]  avs_byteenable,   // Byte lanes
   output logic [31:0]       avs_readdata,     // Read data
   output logic              avs_waitrequest,  // Hold off master
   input  wire  logic        pulse_line,       // Pulse or phase A pin
   input  wire  logic        direction_line,   // Sign or phase B pin
   output logic [31:0]       position_cmd,     // Scaled position
   output logic              position_update   // Scaling batch done pulse
);

   // ==========================================================
   // Settings
   logic        direction_invert_setting;
   logic [1:0]  input_format_setting;
   logic [20:0] pulses_per_rev_setting;
   logic [30:0] gear_numerator_setting;
   logic [30:0] gear_denominator_setting;
   logic [30:0] encoder_res_r;
   logic [31:0] input_count_r;
   logic [31:0] readdata_nxt;
   logic        req;
   logic        wr_en;

   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign req   = avs_read || avs_write;
   assign wr_en = avs_write && !avs_waitrequest;

   // ==========================================================
   // Avalon handshake: answer one cycle after the request
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= readdata_nxt;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         direction_invert_setting <= pulse_gear_pkg::INV_RST;
         input_format_setting     <= pulse_gear_pkg::FMT_RST;
         pulses_per_rev_setting   <= pulse_gear_pkg::PPR_RST;
         gear_numerator_setting   <= pulse_gear_pkg::NUM_RST;
         gear_denominator_setting <= pulse_gear_pkg::DEN_RST;
         encoder_res_r            <= pulse_gear_pkg::ENC_RST;
      end else if (wr_en) begin
         case (avs_address)
            pulse_gear_pkg::OFS_CTRL: begin
               if (avs_byteenable[0]) begin
                  direction_invert_setting <=
                     avs_writedata[pulse_gear_pkg::CTRL_INV_BIT];
                  input_format_setting <=
                     avs_writedata[pulse_gear_pkg::CTRL_FMT_LSB +: 2];
               end
            end
            pulse_gear_pkg::OFS_PPR: pulses_per_rev_setting <=
               21'(be_merge({11'h000, pulses_per_rev_setting},
                            avs_writedata, avs_byteenable));
            pulse_gear_pkg::OFS_NUM: gear_numerator_setting <=
               31'(be_merge({1'b0, gear_numerator_setting},
                            avs_writedata, avs_byteenable));
            pulse_gear_pkg::OFS_DEN: gear_denominator_setting <=
               31'(be_merge({1'b0, gear_denominator_setting},
                            avs_writedata, avs_byteenable));
            pulse_gear_pkg::OFS_ENC: encoder_res_r <=
               31'(be_merge({1'b0, encoder_res_r},
                            avs_writedata, avs_byteenable));
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Pin synchronisers and edge history
   logic p_s1, p_s2, p_s3;
   logic d_s1, d_s2, d_s3;
   logic raw_up, raw_dn;
   logic step_up_r, step_dn_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         p_s1 <= 1'b0;
         p_s2 <= 1'b0;
         p_s3 <= 1'b0;
         d_s1 <= 1'b0;
         d_s2 <= 1'b0;
         d_s3 <= 1'b0;
      end else begin
         p_s1 <= pulse_line;
         p_s2 <= p_s1;
         p_s3 <= p_s2;
         d_s1 <= direction_line;
         d_s2 <= d_s1;
         d_s3 <= d_s2;
      end
   end

   // ==========================================================
   // Format decode; one step per quadrature edge or rising pulse edge at up to 4 Mpps
   always_comb begin
      raw_up = 1'b0;
      raw_dn = 1'b0;
      case (input_format_setting)
         pulse_gear_pkg::FMT_PULSE_PAIR: begin
            raw_up = p_s2 && !p_s3 && !(d_s2 && !d_s3);
            raw_dn = d_s2 && !d_s3 && !(p_s2 && !p_s3);
         end
         pulse_gear_pkg::FMT_PULSE_DIR: begin
            raw_up = p_s2 && !p_s3 && d_s2;
            raw_dn = p_s2 && !p_s3 && !d_s2;
         end
         default: begin
            if ((p_s2 ^ p_s3) != (d_s2 ^ d_s3)) begin
               raw_up = (p_s2 == d_s3);
               raw_dn = (p_s2 != d_s3);
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         step_up_r <= 1'b0;
         step_dn_r <= 1'b0;
      end else begin
         step_up_r <= direction_invert_setting ? raw_dn : raw_up;
         step_dn_r <= direction_invert_setting ? raw_up : raw_dn;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         input_count_r <= 32'h00000000;
      end else if (step_up_r) begin
         input_count_r <= input_count_r + 32'h00000001;
      end else if (step_dn_r) begin
         input_count_r <= input_count_r - 32'h00000001;
      end
   end

   // ==========================================================
   // Ratio selection and scaling
   pulse_gear_pkg::scale_state_e sc_r;
   logic [30:0]        num_sel, den_sel, den_cur_r, rem_r, rem_base;
   logic signed [15:0] pend_r;
   logic signed [47:0] prod, dvd, qs;
   logic [47:0]        mag, div_q;
   logic [30:0]        div_r, rem_nxt;
   logic               neg_r, take, div_busy, div_done;

   always_comb begin
      if (pulses_per_rev_setting != 21'h000000) begin
         num_sel = encoder_res_r;
         den_sel = {10'h000, pulses_per_rev_setting};
      end else if (gear_numerator_setting == 31'h00000000) begin
         num_sel = encoder_res_r;
         den_sel = gear_denominator_setting;
      end else begin
         num_sel = gear_numerator_setting;
         den_sel = gear_denominator_setting;
      end
      if (den_sel == 31'h00000000) begin
         den_sel = 31'h00000001;
      end
   end

   assign take     = (sc_r == pulse_gear_pkg::SC_IDLE) && (pend_r != 16'sh0000);
   assign rem_base = (rem_r >= den_sel) ? 31'h00000000 : rem_r;
   assign prod     = pend_r * $signed({1'b0, num_sel});
   assign dvd      = prod + $signed({17'h00000, rem_base});
   assign mag      = dvd[47] ? 48'(-dvd) : 48'(dvd);

   always_comb begin
      qs      = $signed(div_q);
      rem_nxt = div_r;
      if (neg_r) begin
         if (div_r == 31'h00000000) begin
            qs = -$signed(div_q);
         end else begin
            qs      = -$signed(div_q) - 48'sh000000000001;
            rem_nxt = den_cur_r - div_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pend_r <= 16'sh0000;
      end else begin
         pend_r <= (take ? 16'sh0000 : pend_r)
                 + (step_up_r ? 16'sh0001 : 16'sh0000)
                 - (step_dn_r ? 16'sh0001 : 16'sh0000);
      end
   end

   always_ff @(posedge clk) begin
      position_update <= 1'b0;
      if (srst) begin
         sc_r         <= pulse_gear_pkg::SC_IDLE;
         neg_r        <= 1'b0;
         den_cur_r    <= pulse_gear_pkg::DEN_RST;
         rem_r        <= 31'h00000000;
         position_cmd <= 32'h00000000;
      end else begin
         case (sc_r)
            pulse_gear_pkg::SC_IDLE: begin
               if (take) begin
                  neg_r     <= dvd[47];
                  den_cur_r <= den_sel;
                  sc_r      <= pulse_gear_pkg::SC_WAIT;
               end
            end
            pulse_gear_pkg::SC_WAIT: begin
               if (div_done) begin
                  rem_r           <= rem_nxt;
                  position_cmd    <= position_cmd + qs[31:0];
                  position_update <= 1'b1;
                  sc_r            <= pulse_gear_pkg::SC_IDLE;
               end
            end
            default: sc_r <= pulse_gear_pkg::SC_IDLE;
         endcase
      end
   end

   gear_divider u_div (
      .clk       (clk),
      .srst      (srst),
      .start     (take),
      .dividend  (mag),
      .divisor   (den_sel),
      .busy      (div_busy),
      .done      (div_done),
      .quotient  (div_q),
      .remainder (div_r)
   );

   // ==========================================================
   // Read mux
   always_comb begin
      case (avs_address)
         pulse_gear_pkg::OFS_CTRL:  readdata_nxt = {29'h00000000,
            input_format_setting, direction_invert_setting};
         pulse_gear_pkg::OFS_PPR:   readdata_nxt = {11'h000,
            pulses_per_rev_setting};
         pulse_gear_pkg::OFS_NUM:   readdata_nxt = {1'b0,
            gear_numerator_setting};
         pulse_gear_pkg::OFS_DEN:   readdata_nxt = {1'b0,
            gear_denominator_setting};
         pulse_gear_pkg::OFS_ENC:   readdata_nxt = {1'b0, encoder_res_r};
         pulse_gear_pkg::OFS_COUNT: readdata_nxt = input_count_r;
         pulse_gear_pkg::OFS_POS:   readdata_nxt = position_cmd;
         pulse_gear_pkg::OFS_STAT:  readdata_nxt = {30'h00000000,
            (rem_r != 31'h00000000), div_busy};
         default:                   readdata_nxt = 32'h00000000;
      endcase
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   logic quad_mode;
   assign quad_mode = !input_format_setting[0];

   a_quad_lead_pos: assert property (
      quad_mode && !direction_invert_setting && (p_s2 ^ p_s3)
      && !(d_s2 ^ d_s3) && (p_s2 == d_s3) |=> step_up_r && !step_dn_r)
      else $error("quadrature lead did not count up");

   a_quad_inv_neg: assert property (
      quad_mode && direction_invert_setting && (d_s2 ^ d_s3)
      && !(p_s2 ^ p_s3) && (p_s2 == d_s3) |=> step_dn_r && !step_up_r)
      else $error("inverted quadrature lead did not count down");

   a_dir_fmt_inv: assert property (
      input_format_setting == pulse_gear_pkg::FMT_PULSE_DIR && p_s2 && !p_s3
      && d_s2 && direction_invert_setting |=> step_dn_r ##1
      input_count_r == $past(input_count_r) - 32'h00000001)
      else $error("inverted pulse plus direction step wrong");

   a_ppr_ratio_sel: assert property (
      pulses_per_rev_setting != 21'h000000 |->
      den_sel == {10'h000, pulses_per_rev_setting} && num_sel == encoder_res_r)
      else $error("per-revolution ratio not selected");

   a_gear_ratio_sel: assert property (
      pulses_per_rev_setting == 21'h000000 && gear_numerator_setting != 0
      |-> num_sel == gear_numerator_setting)
      else $error("gear numerator not selected");

   a_num_reset_val: assert property (
      $fell(srst) |-> gear_numerator_setting == 31'h00000000
      && num_sel == encoder_res_r)
      else $error("numerator reset or gating wrong");

   a_den_gear_sel: assert property (
      pulses_per_rev_setting == 21'h000000 && gear_denominator_setting != 0
      |-> den_sel == gear_denominator_setting)
      else $error("gear denominator not applied");

   a_rem_bounded: assert property (
      div_done |=> rem_r < den_cur_r && position_update)
      else $error("remainder not below divisor");

   a_batch_bound: assert property (
      take |-> ##[48:50] position_update)
      else $error("scaling batch did not finish in time");

   c_quad_step:  cover property (quad_mode && step_up_r);
   c_pair_step:  cover property (input_format_setting ==
                                 pulse_gear_pkg::FMT_PULSE_PAIR && step_dn_r);
   c_gear_batch: cover property (pulses_per_rev_setting == 0 && div_done);
   c_rem_carry:  cover property (position_update && rem_r != 0);

endmodule

`default_nettype wire

// ### verification/pulse_host.sv
// Host position controller model that drives the command pulse pins.
// Assumes the bench calls send() from one process; single clock domain.
`timescale 1ns/10ps
`default_nettype none

module pulse_host (
   input  wire logic clk,            // 25 MHz clock
   output var  logic pulse_line,     // Phase A, forward train or pulse
   output var  logic direction_line  // Phase B, reverse train or sign
);
   // ==========================================================
   // Edge spacing
   localparam int GAP = 4;  // Edges 160 ns apart, under 4 Mpps

   logic [1:0] ph;

   initial begin
      pulse_line     = 1'b0;
      direction_line = 1'b0;
      ph             = 2'h0;
   end

   task automatic hold();
      repeat (GAP) @(posedge clk);
   endtask

   // ==========================================================
   // Step generator: fmt 0/2 quadrature, 1 pulse pair, 3 pulse + sign
   task automatic send(input logic [1:0] fmt, input logic neg,
                       input int n);
      @(posedge clk);
      if (fmt == 2'h3) begin
         direction_line <= ~neg;
         hold();
      end
      for (int i = 0; i < n; i++) begin
         if (fmt == 2'h0 || fmt == 2'h2) begin
            ph = neg ? ph - 2'h1 : ph + 2'h1;
            pulse_line     <= ph[1];
            direction_line <= ph[1] ^ ph[0];
            hold();
         end else begin
            if (fmt == 2'h1 && neg) begin
               direction_line <= 1'b1;
            end else begin
               pulse_line <= 1'b1;
            end
            hold();
            pulse_line     <= 1'b0;
            direction_line <= (fmt == 2'h3) ? ~neg : 1'b0;
            hold();
         end
      end
      direction_line <= (fmt == 2'h0 || fmt == 2'h2) ? ph[1] ^ ph[0] : 1'b0;
      hold();
   endtask

endmodule

`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the command pulse decoder with electronic gear.
// Assumes the design answers every bus request; the watchdog ends a hang.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
   logic        clk;
   logic        srst;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pulse_line;
   logic        direction_line;
   logic [31:0] position_cmd;
   logic        position_update;
   logic [31:0] rd;
   logic [31:0] exp_cnt;
   logic [31:0] exp_pos;
   int          num_errors = 0;
   int          check_count = 0;
   int          upd_cnt = 0;
   int          upd_base;

   command_pulse_decoder_gear command_pulse_decoder_gear_i (
      .clk             (clk),
      .srst            (srst),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (4'hF),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .pulse_line      (pulse_line),
      .direction_line  (direction_line),
      .position_cmd    (position_cmd),
      .position_update (position_update)
   );

   pulse_host pulse_host_i (
      .clk            (clk),
      .pulse_line     (pulse_line),
      .direction_line (direction_line)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Counts position update pulses
   always @(posedge clk) begin
      if (position_update === 1'b1) begin
         upd_cnt <= upd_cnt + 1;
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp,
                        input string what);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_read      <= ~wr;
      avs_write     <= wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp,
                        input string what);
      bus(1'b0, a, 32'h00000000);
      check(rd, exp, what);
   endtask

   task automatic do_reset();
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
   endtask

   // Two scaling batches fit in this span
   task automatic steps(input logic [1:0] f, input logic neg, input int n);
      pulse_host_i.send(f, neg, n);
      repeat (120) @(posedge clk);
   endtask

   // ==========================================================
   // Tests
   initial begin
      srst          = 1'b1;
      avs_address   = 5'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h00000000;
      repeat (10) @(posedge clk);
      srst <= 1'b0;

      rdchk(pulse_gear_pkg::OFS_CTRL, 32'h00000002, "ctrl reset");
      rdchk(pulse_gear_pkg::OFS_PPR, 32'h00002710, "ppr reset");
      rdchk(pulse_gear_pkg::OFS_NUM, 32'h00000000, "num reset");
      rdchk(pulse_gear_pkg::OFS_DEN, 32'h00002710, "den reset");
      $display("test reset values done");

      exp_cnt = 32'h00000000;
      for (int f = 0; f < 4; f++) begin
         for (int v = 0; v < 2; v++) begin
            for (int s = 0; s < 2; s++) begin
               wr(pulse_gear_pkg::OFS_CTRL, {29'h0, f[1:0], v[0]});
               steps(f[1:0], s[0], 4);
               exp_cnt = (s[0] ^ v[0]) ? exp_cnt - 32'h4 : exp_cnt + 32'h4;
               rdchk(pulse_gear_pkg::OFS_COUNT, exp_cnt, "count");
            end
         end
      end
      wr(pulse_gear_pkg::OFS_COUNT, 32'h00000055);
      rdchk(pulse_gear_pkg::OFS_COUNT, exp_cnt, "count read-only");
      $display("test formats and direction done");

      do_reset();
      wr(pulse_gear_pkg::OFS_PPR, 32'h00000000);
      wr(pulse_gear_pkg::OFS_NUM, 32'h00000003);
      wr(pulse_gear_pkg::OFS_DEN, 32'h00000002);
      upd_base = upd_cnt;
      for (int k = 1; k <= 3; k++) begin
         steps(pulse_gear_pkg::FMT_PULSE_PAIR, 1'b0, 1);
         exp_pos = 32'((3 * k) / 2);
         rdchk(pulse_gear_pkg::OFS_POS, exp_pos, "gear pos");
         check(position_cmd, exp_pos, "gear pin");
         check(upd_cnt, upd_base + k, "update pulse");
      end
      steps(pulse_gear_pkg::FMT_PULSE_PAIR, 1'b0, 5);
      check(position_cmd, 32'h0000000C, "gear burst");
      $display("test electronic gear done");

      wr(pulse_gear_pkg::OFS_CTRL, 32'h00000006);
      wr(pulse_gear_pkg::OFS_PPR, 32'h00000004);
      steps(pulse_gear_pkg::FMT_PULSE_DIR, 1'b0, 4);
      check(position_cmd, 32'h0010000C, "one revolution");
      $display("test pulses per revolution done");
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge clk);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_sim();
   end

endmodule

`default_nettype wire
